// ===== hw/ecvs_regs.svh
// Constants for the edge count voltage select block
`ifndef ECVS_REGS_SVH
`define ECVS_REGS_SVH

// Reference clock rate in MHz (20 ns period)
`define ECVS_CLK_MHZ          50
// Highest documented program edge rate, in kHz
`define ECVS_MAX_EDGE_KHZ     1000
// Latch hold time after the last edge, in microseconds
`define ECVS_LATCH_HOLD_US    500
// Low level that disables the part, in microseconds
`define ECVS_DISABLE_LOW_US   500
// Least low width before a rising edge counts, in ns
`define ECVS_MIN_PULSE_NS     100

// Cycle counts; least times round up
`define ECVS_LATCH_HOLD_CYC   (`ECVS_LATCH_HOLD_US * `ECVS_CLK_MHZ)
`define ECVS_DISABLE_LOW_CYC  (`ECVS_DISABLE_LOW_US * `ECVS_CLK_MHZ)
`define ECVS_MIN_PULSE_CYC    \
  ((`ECVS_MIN_PULSE_NS * `ECVS_CLK_MHZ + 999) / 1000)

// Edge counting and set-point coding
`define ECVS_MAX_EDGES        5'h10
`define ECVS_DEFAULT_CODE     4'h0
`define ECVS_CNT_W            20

`endif

// ===== hw/ecvs_pkg.sv
// Types shared by the edge count voltage select block
package ecvs_pkg;

  // Program line states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_PROG,
    ST_ON
  } ecvs_state_t;

  typedef logic [19:0] ecvs_cnt_t;
  typedef logic [4:0]  ecvs_edges_t;
  typedef logic [3:0]  ecvs_code_t;

endpackage

// ===== hw/ecvs_pin_if.sv
// Filtered pin levels and events passed from the pin stage to the core
`timescale 1ns/1ps
interface ecvs_pin_if;
  logic en_level;
  logic en_rise;
  logic sel_level;

  modport src (output en_level, output en_rise, output sel_level);
  modport dst (input  en_level, input  en_rise, input  sel_level);
endinterface

// ===== hw/ecvs_pinsync.sv
// Three-stage pin synchroniser with agreement filter and edge detect
`timescale 1ns/1ps
module ecvs_pinsync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sel_pin,
  input  wire logic en_pin,
  ecvs_pin_if.src   pins
);
  logic [1:0] raw;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] filt;
  logic [1:0] next_filt;
  logic       rise;

  // Bit 0 is the select pin, bit 1 the enable/program line
  assign raw = {en_pin, sel_pin};

  // A change counts only once stages two and three agree
  generate
    for (genvar i = 0; i < 2; i++) begin : g_pin
      assign next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
      always_ff @(posedge clk) begin
        if (rst) begin
          s1[i]   <= 1'b0;
          s2[i]   <= 1'b0;
          s3[i]   <= 1'b0;
          filt[i] <= 1'b0;
        end else begin
          s1[i]   <= raw[i];
          s2[i]   <= s1[i];
          s3[i]   <= s2[i];
          filt[i] <= next_filt[i];
        end
      end
    end
  endgenerate

  // Rising edge pulse lines up with the new filtered level
  always_ff @(posedge clk) begin
    if (rst) begin
      rise <= 1'b0;
    end else begin
      rise <= next_filt[1] & ~filt[1];
    end
  end

  assign pins.sel_level = filt[0];
  assign pins.en_level  = filt[1];
  assign pins.en_rise   = rise;

  // Edge pulse only comes with a high line
  a_rise_level: assert property (@(posedge clk) disable iff (rst)
    rise |-> filt[1])
    else $error("rise pulse without high level");
endmodule // ecvs_pinsync

// ===== hw/ecvs_top.sv
// Edge count voltage select core: reference select and pulse programming
//
// Functional notes
// - Select high: high reference active, low reference off.
// - Select low: low reference active, high reference off.
// - Count rising edges on program line into sixteen states.
// - Count n gives low reference 0.60 V plus 0.04 V per step.
// - Edges up to 1 MHz accepted; host stays at or below it.
// - Line held high for latch time latches count to output.
// - Line low beyond disable timeout disables the device.
// - Disable resets setting to default low reference.
// - After reset, before programming, default low reference applies.
// - Select toggles switch set-point directly, no programming.
`timescale 1ns/1ps
`include "ecvs_regs.svh"
module ecvs_top
  import ecvs_pkg::*;
#(
  parameter int unsigned LATCH_HOLD_CYC  = `ECVS_LATCH_HOLD_CYC,
  parameter int unsigned DISABLE_LOW_CYC = `ECVS_DISABLE_LOW_CYC,
  parameter int unsigned MIN_PULSE_CYC   = `ECVS_MIN_PULSE_CYC
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic       SEL_PIN,
  input  wire logic       EN_SET_PIN,
  output logic            HIGH_REF_EN,
  output logic            LOW_REF_EN,
  output logic [3:0]      LOW_REF_CODE,
  output logic            DEVICE_ON
);

  // Saturating edge increment, used by the edge tally only
  function automatic ecvs_edges_t sat_inc(input ecvs_edges_t n);
    sat_inc = (n >= `ECVS_MAX_EDGES) ? `ECVS_MAX_EDGES : n + 5'h01;
  endfunction

  // Edge count 1..16 to code 0..15; step is 40 mV above 0.60 V
  function automatic ecvs_code_t edges_to_code(input ecvs_edges_t n);
    edges_to_code = (n == 5'h00) ? `ECVS_DEFAULT_CODE : 4'(n - 5'h01);
  endfunction

  ecvs_pin_if  pins ();

  ecvs_state_t state;
  ecvs_state_t next_state;
  ecvs_edges_t pend;
  ecvs_edges_t next_pend;
  ecvs_cnt_t   hi_cnt;
  ecvs_cnt_t   next_hi_cnt;
  ecvs_cnt_t   low_cnt;
  ecvs_cnt_t   next_low_cnt;
  ecvs_code_t  next_code;
  logic        next_on;
  logic        rise_ok;
  logic        latch_now;
  logic        off_now;
  ecvs_cnt_t   latch_last;
  ecvs_cnt_t   dis_last;
  ecvs_cnt_t   dis_full;
  ecvs_cnt_t   min_low;

  // Both pins are asynchronous to REF_CLK
  ecvs_pinsync u_sync (
    .clk     (REF_CLK),
    .rst     (RST),
    .sel_pin (SEL_PIN),
    .en_pin  (EN_SET_PIN),
    .pins    (pins.src)
  );

  // Timing limits cut to counter width
  assign latch_last = `ECVS_CNT_W'(LATCH_HOLD_CYC - 1);
  assign dis_last   = `ECVS_CNT_W'(DISABLE_LOW_CYC - 1);
  assign dis_full   = `ECVS_CNT_W'(DISABLE_LOW_CYC);
  assign min_low    = `ECVS_CNT_W'(MIN_PULSE_CYC);

  // Short low glitches are not edges; a 1 MHz host stays well clear
  assign rise_ok   = pins.en_rise && (low_cnt >= min_low);
  assign latch_now = (state == ST_PROG) && pins.en_level
                     && (hi_cnt == latch_last);
  assign off_now   = (state != ST_OFF) && !pins.en_level
                     && (low_cnt == dis_last);

  // Low time saturates so a long-off line still reads as long low
  assign next_low_cnt = pins.en_level ? '0 :
                        (low_cnt >= dis_full) ? low_cnt :
                        low_cnt + 20'h00001;

  // High time restarts at each counted edge
  assign next_hi_cnt = (!pins.en_level || rise_ok) ? '0 :
                       (hi_cnt >= latch_last) ? hi_cnt :
                       hi_cnt + 20'h00001;

  // Edge tally: fresh sequence from off or latched, else saturating
  assign next_pend = off_now ? 5'h00 :
                     (rise_ok && state != ST_PROG) ? 5'h01 :
                     (rise_ok) ? sat_inc(pend) :
                     pend;

  // Set-point: default on disable, decoded count on latch
  assign next_code = off_now ? `ECVS_DEFAULT_CODE :
                     latch_now ? edges_to_code(pend) :
                     LOW_REF_CODE;

  // Enable follows first edge and drops on the long low
  assign next_on = off_now ? 1'b0 :
                   (state == ST_OFF && rise_ok) ? 1'b1 :
                   DEVICE_ON;

  // Program line sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (rise_ok) begin
          next_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (off_now) begin
          next_state = ST_OFF;
        end else if (latch_now) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (off_now) begin
          next_state = ST_OFF;
        end else if (rise_ok) begin
          next_state = ST_PROG;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // Counters and sequencer state
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state   <= ST_OFF;
      pend    <= 5'h00;
      hi_cnt  <= 20'h00000;
      low_cnt <= `ECVS_CNT_W'(MIN_PULSE_CYC);
    end else begin
      state   <= next_state;
      pend    <= next_pend;
      hi_cnt  <= next_hi_cnt;
      low_cnt <= next_low_cnt;
    end
  end

  // Registered outputs; the reference pair tracks select level only,
  // the host keeps select low while programming the low reference
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      HIGH_REF_EN  <= 1'b0;
      LOW_REF_EN   <= 1'b1;
      LOW_REF_CODE <= `ECVS_DEFAULT_CODE;
      DEVICE_ON    <= 1'b0;
    end else begin
      HIGH_REF_EN  <= pins.sel_level;
      LOW_REF_EN   <= !pins.sel_level;
      LOW_REF_CODE <= next_code;
      DEVICE_ON    <= next_on;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Select high drives the high reference alone
  a_sel_high_ref: assert property (
    pins.sel_level |=> HIGH_REF_EN && !LOW_REF_EN)
    else $error("high reference not selected");

  // Select low drives the low reference alone
  a_sel_low_ref: assert property (
    !pins.sel_level |=> !HIGH_REF_EN && LOW_REF_EN)
    else $error("low reference not selected");

  // Select toggle is followed in one cycle
  a_sel_follow: assert property (
    $changed(pins.sel_level) |=> $changed(HIGH_REF_EN)
                                 && (LOW_REF_EN != HIGH_REF_EN))
    else $error("set-point did not follow select");

  // Counted edge in a sequence adds one, capped at sixteen
  a_edge_count: assert property (
    (rise_ok && state == ST_PROG && !off_now)
      |=> pend == (($past(pend) == `ECVS_MAX_EDGES) ? `ECVS_MAX_EDGES
                   : $past(pend) + 5'h01))
    else $error("edge tally wrong");

  // Tally never leaves 0..16
  a_edge_sat: assert property (
    pend <= `ECVS_MAX_EDGES)
    else $error("edge tally above sixteen");

  // Latch moves the decoded count to the output
  a_latch_code: assert property (
    latch_now |=> LOW_REF_CODE == 4'($past(pend) - 5'h01)
                  && state == ST_ON)
    else $error("latched code wrong");

  // Output code only moves on latch or disable
  a_code_hold: assert property (
    !latch_now && !off_now |=> $stable(LOW_REF_CODE))
    else $error("code moved without latch");

  // Long low disables and restores the default code
  a_disable_default: assert property (
    off_now |=> !DEVICE_ON && LOW_REF_CODE == `ECVS_DEFAULT_CODE
                && state == ST_OFF)
    else $error("disable did not restore default");

  // A low shorter than the timeout keeps the device on
  a_no_early_off: assert property (
    (DEVICE_ON && !pins.en_level && low_cnt < dis_last) |=> DEVICE_ON)
    else $error("disabled before timeout");

  // First edge from off enables and counts as one
  a_reenable: assert property (
    (state == ST_OFF && rise_ok) |=> DEVICE_ON && pend == 5'h01
                                     && state == ST_PROG)
    else $error("re-enable edge mishandled");

  // Reset leaves the default low reference; must not be gated by reset
  a_reset_default: assert property (@(posedge REF_CLK)
    disable iff (1'b0)
    RST |=> LOW_REF_CODE == `ECVS_DEFAULT_CODE && !DEVICE_ON)
    else $error("reset code not default");

  // Main scenarios
  c_latch_seen:   cover property (latch_now);
  c_disable_seen: cover property (off_now);
  c_saturated:    cover property (latch_now && pend == `ECVS_MAX_EDGES);
  c_reprogram:    cover property (state == ST_ON && rise_ok);

endmodule // ecvs_top

// ===== bench/ecvs_host.sv
// Host model driving the select pin and the enable/program line
`timescale 1ns/1ps
module ecvs_host (
  input  wire logic clk,
  output logic      sel,
  output logic      en
);
  // Half period of a 1 MHz program clock at 20 ns
  localparam int HALF = 25;

  // Both pins start low so the part powers up disabled
  initial begin
    sel = 1'b0;
    en  = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic set_sel(input logic v);
    @(posedge clk);
    sel <= v;
  endtask

  // Edge burst; low gap stays well under the disable timeout
  task automatic burst(input int n);
    @(posedge clk);
    sel <= 1'b0;
    for (int i = 0; i < n; i++) begin
      en <= 1'b0;
      repeat (HALF) @(posedge clk);
      en <= 1'b1;
      repeat (HALF) @(posedge clk);
    end
  endtask

  // Line stays high after the burst so the count latches
  task automatic latch(input int n);
    en <= 1'b1;
    repeat (n) @(posedge clk);
  endtask

  // Long low level to switch the part off
  task automatic go_low(input int n);
    en <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
endmodule // ecvs_host

// ===== bench/ecvs_top_bench.sv
// Self-checking bench for the edge count voltage select core
`timescale 1ns/1ps
module ecvs_top_bench;
  import ecvs_pkg::*;
  localparam int LATCH = 40;
  localparam int DIS   = 60;

  logic       ref_clk;
  logic       rst;
  logic       sel_pin;
  logic       en_set_pin;
  logic       high_ref_en;
  logic       low_ref_en;
  logic [3:0] low_ref_code;
  logic       device_on;
  int         n_fail;
  int         checked;

  // Short counts keep the run brief
  ecvs_top #(
    .LATCH_HOLD_CYC  (LATCH),
    .DISABLE_LOW_CYC (DIS),
    .MIN_PULSE_CYC   (3)
  ) u_dut (
    .REF_CLK      (ref_clk),
    .RST          (rst),
    .SEL_PIN      (sel_pin),
    .EN_SET_PIN   (en_set_pin),
    .HIGH_REF_EN  (high_ref_en),
    .LOW_REF_EN   (low_ref_en),
    .LOW_REF_CODE (low_ref_code),
    .DEVICE_ON    (device_on)
  );

  ecvs_host u_host (
    .clk (ref_clk),
    .sel (sel_pin),
    .en  (en_set_pin)
  );

  // 50 MHz clock
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  // Compare away from the clock edge so outputs have settled
  task automatic check(input string what, input logic [3:0] seen,
                       input logic [3:0] exp);
    @(negedge ref_clk);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    check("high_ref_en", 4'(high_ref_en), 4'h0);
    check("low_ref_en", 4'(low_ref_en), 4'h1);
    check("low_ref_code", low_ref_code, 4'h0);
    check("device_on", 4'(device_on), 4'h0);
  endtask

  task automatic t_select();
    u_host.set_sel(1'b1);
    u_host.wait_cyc(8);
    check("high_ref_en", 4'(high_ref_en), 4'h1);
    check("low_ref_en", 4'(low_ref_en), 4'h0);
    u_host.set_sel(1'b0);
    u_host.wait_cyc(8);
    check("high_ref_en", 4'(high_ref_en), 4'h0);
    check("low_ref_en", 4'(low_ref_en), 4'h1);
  endtask

  // Every edge count through the whole table; only the first starts from off
  task automatic t_table();
    for (int n = 1; n <= 16; n++) begin
      u_host.burst(n);
      u_host.latch(LATCH + 20);
      check("low_ref_code", low_ref_code, 4'(n - 1));
      check("device_on", 4'(device_on), 4'h1);
    end
  endtask

  task automatic t_saturate();
    u_host.burst(18);
    u_host.latch(LATCH + 20);
    check("low_ref_code", low_ref_code, 4'hF);
  endtask

  // Programmed code survives select toggles in both directions
  task automatic t_sel_keep();
    u_host.burst(3);
    u_host.latch(LATCH + 20);
    u_host.set_sel(1'b1);
    u_host.wait_cyc(8);
    check("high_ref_en", 4'(high_ref_en), 4'h1);
    u_host.set_sel(1'b0);
    u_host.wait_cyc(8);
    check("low_ref_en", 4'(low_ref_en), 4'h1);
    check("low_ref_code", low_ref_code, 4'h2);
  endtask

  // Disable mid-setting, then a single edge restarts at default
  task automatic t_disable();
    u_host.burst(5);
    u_host.latch(LATCH + 20);
    check("low_ref_code", low_ref_code, 4'h4);
    u_host.go_low(DIS + 20);
    check("device_on", 4'(device_on), 4'h0);
    check("low_ref_code", low_ref_code, 4'h0);
    u_host.burst(1);
    u_host.latch(LATCH + 20);
    check("device_on", 4'(device_on), 4'h1);
    check("low_ref_code", low_ref_code, 4'h0);
  endtask

  // Low glitch under the least pulse width adds no edge
  task automatic t_glitch();
    u_host.burst(4);
    u_host.go_low(2);
    u_host.latch(LATCH + 20);
    check("low_ref_code", low_ref_code, 4'h3);
  endtask

  // Mid-run reset drops the programmed code; line stays high meanwhile
  task automatic t_midreset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
  endtask

  // Main sequence; reset held for ten cycles
  initial begin
    n_fail  = 0;
    checked = 0;
    rst     = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_select();
    t_table();
    t_saturate();
    t_sel_keep();
    t_disable();
    t_glitch();
    t_midreset();
    summarize();
  end

  // Watchdog: the tests need about 9800 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end
endmodule // ecvs_top_bench
